/* design/rx_buffer.sv */
// receive buffer: two entry fifo with status per entry and legacy mode
//
// Added by the designer: strobed register access and the address map.
`timescale 1ns/100ps
`default_nettype none
// Notes on behaviour
// R1: two entry receive fifo in normal mode
// R2: legacy fuse disables fifo operation
// R3: software reads data once per character
// R4: flags and ninth bit stored per entry
// R5: software reads status before data
// R6: ninth bit reads zero after reset
// R7: selectable double speed receive mode
// R8: extra entry delays overrun by one character
// R9: data read pops oldest, shows next
module rx_buffer (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // fuse strap, static
  input wire logic legacy_compat_fuse,
  // serial line
  input wire logic rxd_pin,
  // register port
  input wire logic [2:0] addr,
  input wire logic [15:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [15:0] rdata,
  // interrupt
  output logic irq
);
  import rxbuf_pkg::*;
  // entry layout: {overrun, framing, ninth, data[7:0]}
  localparam int EW = 11;
  logic [EW-1:0] mem_q [2], mem_d [2]; // entry array
  logic [1:0] cnt_q, cnt_d; // entries held
  logic ovr_pend_q, ovr_pend_d; // overrun for next stored entry
  logic [2:0] ctrl_q, ctrl_d;
  logic [15:0] div_q, div_d;
  logic [IRQ_W-1:0] ist_q, ist_d, imask_q, imask_d;
  logic [15:0] rdata_d;
  logic irq_d;
  logic s1_q, s2_q; // line synchroniser
  logic f1_q, f2_q; // fuse strap synchroniser
  logic [EW-1:0] hd; // head entry, zero when empty
  logic fuse_q; // fuse captured while reset holds
  logic done, ferr;
  logic [8:0] fdata;
  logic [1:0] depth;
  logic pop;
  // entry as seen at the head, zero when empty
  function automatic logic [EW-1:0] head(input logic [1:0] n, input logic [EW-1:0] e);
    head = (n != 2'h0) ? e : '0;
  endfunction
  rx_serial u_rx (
    .clk(clk),
    .srst(srst),
    .enable(ctrl_q[CTRL_EN]),
    .dbl_speed(ctrl_q[CTRL_DBL]), // [R7]
    .nine_bits(ctrl_q[CTRL_NINE]),
    .baud_div(div_q),
    .rxd(s2_q),
    .done(done),
    .data(fdata),
    .ferr(ferr)
  );
  // synchroniser and fuse capture; fuse sampled while reset holds
  always_ff @(posedge clk) begin
    s1_q <= rxd_pin;
    s2_q <= s1_q;
    // the strap is a pin: two flops before it is captured
    f1_q <= legacy_compat_fuse;
    f2_q <= f1_q;
    if (srst) begin
      fuse_q <= f2_q;
    end
  end
  // legacy mode keeps one entry: no queueing [R2]
  assign depth = fuse_q ? 2'h1 : 2'h2; // [R1]
  assign pop = rd && (addr == ADDR_DATA) && (cnt_q != 2'h0); // [R9]
  assign hd = head(cnt_q, mem_q[0]);
  // buffer, registers and interrupt next state
  always_comb begin
    logic [1:0] n;
    logic full;
    n = cnt_q;
    full = 1'b0;
    mem_d = mem_q;
    ovr_pend_d = ovr_pend_q;
    ctrl_d = ctrl_q;
    div_d = div_q;
    imask_d = imask_q;
    ist_d = ist_q;
    rdata_d = 16'h0000;
    // a read pops the oldest entry and shifts the next up [R9]
    if (pop) begin
      mem_d[0] = mem_q[1];
      n = cnt_q - 2'h1;
    end
    full = (n >= depth); // [R8]
    if (done) begin
      if (full) begin
        // no room: the frame is lost, flag rides on next stored one
        ovr_pend_d = 1'b1;
        ist_d[IRQ_OVR] = 1'b1;
      end else begin
        // status kept with its character [R4]
        mem_d[n[0]] = {ovr_pend_q, ferr, fdata};
        ovr_pend_d = 1'b0;
        n = n + 2'h1;
        ist_d[IRQ_RX] = 1'b1;
        if (ferr) begin
          ist_d[IRQ_FE] = 1'b1;
        end
      end
    end
    cnt_d = n;
    // register writes; a same cycle set survives a clear by one only if the bit was clear
    if (wr) begin
      case (addr)
        ADDR_CTRL: ctrl_d = wdata[2:0];
        ADDR_DIV: div_d = wdata;
        ADDR_MASK: imask_d = wdata[IRQ_W-1:0];
        ADDR_IRQ: ist_d = ist_q & ~wdata[IRQ_W-1:0] | (ist_d & ~ist_q);
        default: ;
      endcase
    end
    // reads; status must come before data since data read pops [R5]
    if (rd) begin
      case (addr)
        ADDR_DATA: rdata_d = {8'h00, hd[7:0]}; // [R3]
        ADDR_STAT: begin
          rdata_d[STAT_FE] = hd[9];
          rdata_d[STAT_OVR] = hd[10];
          rdata_d[STAT_B8] = hd[8]; // [R6]
          rdata_d[STAT_AVAIL] = (cnt_q != 2'h0);
          rdata_d[STAT_COMPAT] = fuse_q;
        end
        ADDR_CTRL: rdata_d = {13'h0000, ctrl_q};
        ADDR_IRQ: rdata_d = {12'h000, ist_q};
        ADDR_MASK: rdata_d = {12'h000, imask_q};
        ADDR_DIV: rdata_d = div_q;
        default: rdata_d = 16'h0000;
      endcase
    end
    irq_d = |(ist_d & imask_d);
  end
  // state registers; entries clear so ninth bit reads zero [R6]
  always_ff @(posedge clk) begin
    if (srst) begin
      mem_q[0] <= '0;
      mem_q[1] <= '0;
      cnt_q <= 2'h0;
      ovr_pend_q <= 1'b0;
      ctrl_q <= CTRL_RST;
      div_q <= DIV_RST;
      ist_q <= '0;
      imask_q <= '0;
      rdata <= 16'h0000;
      irq <= 1'b0;
    end else begin
      mem_q <= mem_d;
      cnt_q <= cnt_d;
      ovr_pend_q <= ovr_pend_d;
      ctrl_q <= ctrl_d;
      div_q <= div_d;
      ist_q <= ist_d;
      imask_q <= imask_d;
      rdata <= rdata_d;
      irq <= irq_d;
    end
  end
endmodule
`default_nettype wire

/* design/rx_serial.sv */
// serial frame receiver with normal and double speed oversampling
`timescale 1ns/100ps
`default_nettype none
module rx_serial (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // configuration
  input wire logic enable,
  input wire logic dbl_speed,
  input wire logic nine_bits,
  input wire logic [15:0] baud_div,
  // synchronised line
  input wire logic rxd,
  // received frame
  output logic done,
  output logic [8:0] data,
  output logic ferr
);
  import rxbuf_pkg::*;
  typedef enum {IDLE, START, BITS, STOP} rx_state_t;
  rx_state_t st_q, st_d;
  logic [15:0] pre_q, pre_d; // baud prescaler
  logic [4:0] tick_q, tick_d; // ticks within bit
  logic [3:0] cnt_q, cnt_d; // data bits taken
  logic [8:0] sh_q, sh_d; // shift register
  logic done_d, ferr_d;
  logic [4:0] ovs, half;
  logic tick;
  logic [3:0] nbits;
  assign ovs = dbl_speed ? OVS_DBL : OVS_NORM; // [R7]
  assign half = ovs >> 1;
  assign tick = (pre_q == 16'h0000);
  assign nbits = nine_bits ? 4'h9 : 4'h8;
  // next state of the frame sampler
  always_comb begin
    st_d = st_q;
    pre_d = tick ? baud_div : pre_q - 16'h0001;
    tick_d = tick_q;
    cnt_d = cnt_q;
    sh_d = sh_q;
    done_d = 1'b0;
    ferr_d = ferr;
    case (st_q)
      IDLE: begin
        tick_d = 5'h00;
        cnt_d = 4'h0;
        if (enable && !rxd) begin
          st_d = START;
          pre_d = baud_div;
        end
      end
      START: if (tick) begin
        tick_d = tick_q + 5'h01;
        // a start bit that is high at mid bit is a glitch
        if (tick_q == half - 5'h01) begin
          tick_d = 5'h00;
          st_d = rxd ? IDLE : BITS;
        end
      end
      BITS: if (tick) begin
        tick_d = tick_q + 5'h01;
        if (tick_q == ovs - 5'h01) begin
          tick_d = 5'h00;
          sh_d = {rxd, sh_q[8:1]};
          cnt_d = cnt_q + 4'h1;
          if (cnt_q == nbits - 4'h1) begin
            st_d = STOP;
          end
        end
      end
      STOP: if (tick) begin
        tick_d = tick_q + 5'h01;
        if (tick_q == ovs - 5'h01) begin
          st_d = IDLE;
          done_d = 1'b1;
          ferr_d = !rxd;
          // right align an eight bit frame
          sh_d = nine_bits ? sh_q : {1'b0, sh_q[8:1]};
        end
      end
      default: st_d = IDLE;
    endcase
  end
  // registers of the sampler
  always_ff @(posedge clk) begin
    if (srst) begin
      st_q <= IDLE;
      pre_q <= 16'h0000;
      tick_q <= 5'h00;
      cnt_q <= 4'h0;
      sh_q <= 9'h000;
      done <= 1'b0;
      ferr <= 1'b0;
    end else begin
      st_q <= st_d;
      pre_q <= pre_d;
      tick_q <= tick_d;
      cnt_q <= cnt_d;
      sh_q <= sh_d;
      done <= done_d;
      ferr <= ferr_d;
    end
  end
  assign data = sh_q;
endmodule
`default_nettype wire

/* design/rxbuf_pkg.sv */
// constants shared by the receive buffer design
package rxbuf_pkg;
  // register offsets on the plain register port
  localparam logic [2:0] ADDR_DATA = 3'h0;
  localparam logic [2:0] ADDR_STAT = 3'h1;
  localparam logic [2:0] ADDR_CTRL = 3'h2;
  localparam logic [2:0] ADDR_IRQ = 3'h3;
  localparam logic [2:0] ADDR_MASK = 3'h4;
  localparam logic [2:0] ADDR_DIV = 3'h5;
  // status field positions
  localparam int STAT_FE = 0;
  localparam int STAT_OVR = 1;
  localparam int STAT_B8 = 2;
  localparam int STAT_AVAIL = 3;
  localparam int STAT_COMPAT = 4;
  // control field positions
  localparam int CTRL_EN = 0;
  localparam int CTRL_DBL = 1;
  localparam int CTRL_NINE = 2;
  // interrupt event positions
  localparam int IRQ_RX = 0;
  localparam int IRQ_FE = 1;
  localparam int IRQ_OVR = 2;
  localparam int IRQ_W = 3;
  // reset values
  localparam logic [2:0] CTRL_RST = 3'h1;
  localparam logic [15:0] DIV_RST = 16'h0035;
  // oversampling per bit in normal and double speed
  localparam logic [4:0] OVS_NORM = 5'h10;
  localparam logic [4:0] OVS_DBL = 5'h08;
endpackage

/* test/rx_buffer_properties.sv */
// assertions watching the receive buffer register port
`timescale 1ns/100ps
`default_nettype none
module rx_buffer_properties (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // strap and register port
  input wire logic legacy_compat_fuse,
  input wire logic [2:0] addr,
  input wire logic [15:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [15:0] rdata,
  input wire logic irq
);
  import rxbuf_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  // data only in the answer cycle
  rdata_idle_a: assert property (!$past(rd) |-> rdata == 16'h0)
    else $error("rdata outside answer");
  unmapped_zero_a: assert property (rd && addr > 3'h5 |=> rdata == 16'h0)
    else $error("unmapped read");
  reset_quiet_a: assert property ($fell(srst) |-> rdata == 16'h0 && !irq)
    else $error("reset state");
  mask_off_a: assert property (wr && addr == ADDR_MASK && wdata[2:0] == 3'h0 |=> ##1 !irq)
    else $error("masked irq");
  // a clear needs a write first
  irq_hold_a: assert property ($fell(irq) |-> $past(wr) || $past(wr, 2))
    else $error("irq dropped");
  compat_bit_a: assert property (rd && addr == ADDR_STAT |=> rdata[4] == legacy_compat_fuse)
    else $error("legacy bit");
  stat_width_a: assert property (rd && addr == ADDR_STAT |=> rdata[15:5] == 11'h0)
    else $error("status width");
  data_width_a: assert property (rd && addr == ADDR_DATA |=> rdata[15:8] == 8'h00)
    else $error("data width");
endmodule
bind rx_buffer rx_buffer_properties chk (.clk, .srst, .legacy_compat_fuse, .addr, .wdata,
  .wr, .rd, .rdata, .irq);
`default_nettype wire

/* test/serial_sender.sv */
// remote serial transmitter model driving the receive line
`timescale 1ns/100ps
`default_nettype none
module serial_sender (
  // clock
  input wire logic clk,
  // serial line, idle high
  output logic line
);
  initial line = 1'b1;
  // start, data lsb first, optional ninth bit, stop, then idle
  task automatic send(input logic [8:0] v, input logic nine, input logic stop, input int bl);
    int n;
    n = nine ? 9 : 8;
    for (int i = -1; i <= n; i++) begin
      @(posedge clk);
      line <= (i < 0) ? 1'b0 : (i == n) ? stop : v[i];
      repeat (bl - 1) @(posedge clk);
    end
    @(posedge clk);
    line <= 1'b1;
    // idle gap lets the receiver finish
    repeat (2 * bl) @(posedge clk);
  endtask
endmodule
`default_nettype wire

/* test/uart_receive_buffer_compat_bench.sv */
// self-checking bench for the receive buffer
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin errors++; \
  $display("BAD t=%0t got %h exp %h", $time, g, e); end end
module uart_receive_buffer_compat_bench;
  import rxbuf_pkg::*;
  logic clk = 1'b0, srst = 1'b1, legacy_compat_fuse = 1'b0, wr = 1'b0, rd = 1'b0;
  logic rxd_pin, irq;
  logic [2:0] addr = 3'h0;
  logic [15:0] wdata = 16'h0, rdata;
  int errors = 0, comparisons = 0;
  // 100 mhz clock
  always #5 clk = ~clk;
  rx_buffer dut (.clk, .srst, .legacy_compat_fuse, .rxd_pin, .addr, .wdata, .wr, .rd,
    .rdata, .irq);
  serial_sender tx (.clk, .line(rxd_pin));
  // one write cycle
  task automatic wr_reg(input logic [2:0] a, input logic [15:0] v);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= v;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  // read strobe, data taken in the answer cycle
  task automatic rc(input logic [2:0] a, input logic [15:0] e);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    // answer stands from this edge to the next; look at it mid cycle
    @(negedge clk);
    `CHK(rdata, e)
  endtask
  // fuse only counts while reset is held
  task automatic do_reset(input logic f);
    @(posedge clk);
    srst <= 1'b1;
    legacy_compat_fuse <= f;
    repeat (5) @(posedge clk);
    srst <= 1'b0;
  endtask
  task automatic close_out;
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    do_reset(1'b0);
    // divider 0 gives sixteen clocks per bit
    wr_reg(ADDR_DIV, 16'h0000);
    wr_reg(ADDR_MASK, 16'h0007);
    wr_reg(ADDR_CTRL, 16'h0005);
    // three frames into two entries, the third is lost
    tx.send(9'h1a5, 1'b1, 1'b1, 16);
    tx.send(9'h03c, 1'b1, 1'b0, 16);
    tx.send(9'h0f0, 1'b1, 1'b1, 16);
    rc(ADDR_STAT, 16'h000c);
    rc(ADDR_DATA, 16'h00a5);
    rc(ADDR_STAT, 16'h0009);
    rc(ADDR_DATA, 16'h003c);
    rc(ADDR_DATA, 16'h0000);
    tx.send(9'h055, 1'b1, 1'b1, 16);
    rc(ADDR_STAT, 16'h000a);
    rc(ADDR_DATA, 16'h0055);
    `CHK(irq, 1'b1)
    rc(ADDR_IRQ, 16'h0007);
    wr_reg(ADDR_MASK, 16'h0000);
    repeat (3) @(posedge clk);
    `CHK(irq, 1'b0)
    wr_reg(ADDR_IRQ, 16'h0007);
    wr_reg(ADDR_MASK, 16'h0007);
    rc(ADDR_IRQ, 16'h0000);
    `CHK(irq, 1'b0)
    // double speed, eight clocks per bit
    wr_reg(ADDR_CTRL, 16'h0003);
    tx.send(9'h0c3, 1'b0, 1'b1, 8);
    rc(ADDR_STAT, 16'h0008);
    rc(ADDR_DATA, 16'h00c3);
    // legacy strap, a single entry
    do_reset(1'b1);
    rc(ADDR_STAT, 16'h0010);
    wr_reg(ADDR_DIV, 16'h0000);
    tx.send(9'h011, 1'b0, 1'b1, 16);
    tx.send(9'h022, 1'b0, 1'b1, 16);
    rc(ADDR_STAT, 16'h0018);
    rc(ADDR_DATA, 16'h0011);
    rc(ADDR_DATA, 16'h0000);
    tx.send(9'h033, 1'b0, 1'b1, 16);
    rc(ADDR_STAT, 16'h001a);
    rc(ADDR_DATA, 16'h0033);
    `CHK(irq, 1'b0)
    // unmapped place and control reset value
    rc(3'h7, 16'h0000);
    wr_reg(3'h6, 16'hffff);
    rc(ADDR_CTRL, 16'h0001);
    close_out;
  end
  // cut a hang short
  initial begin
    #500000;
    errors++;
    close_out;
  end
endmodule
`default_nettype wire
